//--- scl_pkg.sv
// Package for the serial control/status/lock command block
package scl_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WRITE_CONTROL = 8'h0A;
  localparam logic [7:0] OP_READ_STATUS   = 8'h0B;
  localparam logic [7:0] OP_LOCK_PART     = 8'h01;

  // ****************************************
  // Register map (word-aligned byte addresses)
  // ****************************************
  localparam logic [3:0] ADR_CONTROL  = 4'h0;
  localparam logic [3:0] ADR_FLAGS    = 4'h4;
  localparam logic [3:0] ADR_LOCK     = 4'h8;
  localparam logic [3:0] ADR_IRQ_STAT = 4'hC;

  // Second page of the map
  localparam logic [4:0] ADR_IRQ_CLR  = 5'h10;
  localparam logic [4:0] ADR_IRQ_EN   = 5'h14;
  localparam logic [4:0] ADR_WR_CHECK = 5'h18;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          CTRL_W      = 16;
  localparam int          FLAG_W      = 3;
  localparam int          LOCK_W      = 3;
  localparam int          ADDR_W      = 9;
  localparam int          IRQ_W       = 4;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [2:0]  LOCK_RST    = 3'h0;
  localparam int          IRQ_CTRL    = 0;
  localparam int          IRQ_STAT_RD = 1;
  localparam int          IRQ_LOCK    = 2;
  localparam int          IRQ_ABORT   = 3;
  localparam int          BIT_CNT_W   = 5;
  localparam logic [4:0]  BITS_OP     = 5'h08;
  localparam logic [4:0]  BITS_LOCK   = 5'h10;
  localparam logic [4:0]  BITS_CTRL   = 5'h18;

  // Control register fields
  typedef struct packed {
    logic       sleep;
    logic [1:0] gain;
    logic [3:0] balance;
    logic [1:0] fet;
    logic [6:0] spare;
  } scl_ctrl_t;

  // Serial pins after synchronisation
  typedef struct packed {
    logic sck;
    logic sdi;
    logic cs_n;
  } scl_pins_t;

endpackage : scl_pkg

//--- scl_lock_map.sv
// Lock partition decode: is an array address protected
`timescale 1ns/100ps
module scl_lock_map
  import scl_pkg::*;
(
  // Partition and address
  input  wire logic [LOCK_W-1:0] part_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // Result
  output logic                   locked_o
);

  // Eight configurations: 0 none, 1..3 upper quarter/half/all, 4..7 lower ranges
  logic [ADDR_W-1:0] lo_bound;
  logic [ADDR_W-1:0] hi_bound;
  logic              any_lock;

  always_comb begin
    lo_bound = 9'h000;
    hi_bound = 9'h000;
    any_lock = 1'b1;
    case (part_i)
      3'h0: any_lock = 1'b0;
      3'h1: begin lo_bound = 9'h180; hi_bound = 9'h1FF; end
      3'h2: begin lo_bound = 9'h100; hi_bound = 9'h1FF; end
      3'h3: begin lo_bound = 9'h000; hi_bound = 9'h1FF; end
      3'h4: begin lo_bound = 9'h000; hi_bound = 9'h03F; end
      3'h5: begin lo_bound = 9'h000; hi_bound = 9'h07F; end
      3'h6: begin lo_bound = 9'h000; hi_bound = 9'h0FF; end
      default: begin lo_bound = 9'h000; hi_bound = 9'h17F; end
    endcase
  end

  assign locked_o = any_lock && (addr_i >= lo_bound) && (addr_i <= hi_bound);

endmodule : scl_lock_map

//--- scl_core.sv
// Serial command interpreter: control write, status read, lock partition
//
// Summary of operation
// - Control write command overwrites the volatile control register with its data.
// - Control register drives FET, balance, gain outputs and sleep request.
// - No enable or busy wait; next command accepted right after.
// - Status read command shifts out three flags: regulator ready, two faults.
// - Lock command picks one of eight array protection configurations.
// - Writes to addresses inside the locked portion are suppressed; here the core only reports whether an address is locked, via ADR_WR_CHECK.
// - Control write opcode 0x0A, followed by two data bytes loaded.
// - Status read opcode 0x0B, status returned on serial output.
// - Lock opcode 0x01, followed by one partition byte.
// - All bytes MSB first; chip select held low for whole command.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module scl_core
  import scl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [4:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Serial link pins
  input  wire logic              sck_i,
  input  wire logic              sdi_i,
  input  wire logic              cs_n_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  // Device status sources
  input  wire logic [FLAG_W-1:0] flags_i,
  // Device controls
  output logic      [1:0]        fet_o,
  output logic      [3:0]        balance_o,
  output logic      [1:0]        gain_o,
  output logic                   sleep_o,
  output logic      [LOCK_W-1:0] lock_part_o,
  output logic                   irq_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  scl_pins_t pin_meta;
  scl_pins_t pin_sync;
  logic      sck_prev;

  always_ff @(posedge clk_i) begin
    pin_meta <= '{sck: sck_i, sdi: sdi_i, cs_n: cs_n_i};
    pin_sync <= pin_meta;
    sck_prev <= pin_sync.sck;
  end

  wire sck_rise = pin_sync.sck & ~sck_prev;
  wire sck_fall = ~pin_sync.sck & sck_prev;
  wire selected = ~pin_sync.cs_n;

  // ****************************************
  // Command state machine
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_CTRL   = 4'b0010,
    ST_STATUS = 4'b0100,
    ST_LOCK   = 4'b1000
  } scl_state_t;

  scl_state_t            state;
  scl_state_t            next_state;
  logic [BIT_CNT_W-1:0]  bit_cnt;
  logic [23:0]           shift_in;
  logic [7:0]            shift_out;
  scl_ctrl_t             ctrl;
  logic [LOCK_W-1:0]     lock_part;
  logic [FLAG_W-1:0]     flags_meta;
  logic [FLAG_W-1:0]     flags_sync;

  wire [23:0] next_shift = {shift_in[22:0], pin_sync.sdi};
  wire [BIT_CNT_W-1:0] next_cnt = bit_cnt + 5'h01;
  wire op_done   = sck_rise && (next_cnt == BITS_OP);
  wire ctrl_done = sck_rise && (state == ST_CTRL) && (next_cnt == BITS_CTRL);
  wire lock_done = sck_rise && (state == ST_LOCK) && (next_cnt == BITS_LOCK);
  wire stat_start = op_done && (state == ST_IDLE) && (next_shift[7:0] == OP_READ_STATUS);
  wire cs_abort  = ~selected && (state == ST_CTRL);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (op_done) begin
          case (next_shift[7:0])
            OP_WRITE_CONTROL: next_state = ST_CTRL;
            OP_READ_STATUS:   next_state = ST_STATUS;
            OP_LOCK_PART:     next_state = ST_LOCK;
            default:          next_state = ST_IDLE;
          endcase
        end
      end
      ST_CTRL:   if (ctrl_done) next_state = ST_IDLE;
      ST_LOCK:   if (lock_done) next_state = ST_IDLE;
      ST_STATUS: next_state = ST_STATUS;
      default:   next_state = ST_IDLE;
    endcase
    if (!selected) next_state = ST_IDLE;
  end

  // Unknown opcodes park the interpreter until chip select rises
  always_ff @(posedge clk_i) begin
    if (rst_i || !selected) begin
      bit_cnt <= '0;
    end else if (sck_rise && bit_cnt != BITS_CTRL) begin
      bit_cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      shift_in <= '0;
    end else begin
      state <= next_state;
      if (sck_rise) shift_in <= next_shift;
    end
  end

  // ****************************************
  // Control and lock registers
  // ****************************************
  logic wb_wr;
  logic wb_ctrl_wr;
  logic wb_lock_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= CTRL_RST;
      lock_part <= LOCK_RST;
    end else begin
      if (ctrl_done) ctrl <= next_shift[15:0];
      else if (wb_ctrl_wr) ctrl <= dat_i[15:0];
      if (lock_done) lock_part <= next_shift[LOCK_W-1:0];
      else if (wb_lock_wr) lock_part <= dat_i[LOCK_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    fet_o       <= ctrl.fet;
    balance_o   <= ctrl.balance;
    gain_o      <= ctrl.gain;
    sleep_o     <= ctrl.sleep;
    lock_part_o <= lock_part;
    flags_meta  <= flags_i;
    flags_sync  <= flags_meta;
  end

  // ****************************************
  // Status shift out, changes on falling clock
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || !selected) begin
      shift_out <= '0;
      sdo_o     <= 1'b0;
      sdo_oe_o  <= 1'b0;
    end else if (stat_start) begin
      shift_out <= {5'h00, flags_sync};
      sdo_oe_o  <= 1'b1;
    end else if (state == ST_STATUS && sck_fall) begin
      sdo_o     <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_evt;

  assign irq_evt = {cs_abort, lock_done, stat_start, ctrl_done};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      // Set wins over a simultaneous clear
      irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
      irq_o    <= |(irq_stat & irq_en);
    end
  end

  // ****************************************
  // Wishbone slave, one wait state
  // ****************************************
  logic [ADDR_W-1:0] chk_addr;
  logic              chk_locked;

  scl_lock_map u_lock_map (
    .part_i   (lock_part),
    .addr_i   (chk_addr),
    .locked_o (chk_locked)
  );

  wire wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr      = wb_req && we_i && sel_i[0];
  assign wb_ctrl_wr = wb_wr && (adr_i == {1'b0, ADR_CONTROL});
  assign wb_lock_wr = wb_wr && (adr_i == {1'b0, ADR_LOCK});
  assign irq_clr    = (wb_wr && adr_i == ADR_IRQ_CLR) ? dat_i[IRQ_W-1:0] : '0;

  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      {1'b0, ADR_CONTROL}:  rd_mux = {16'h0000, ctrl};
      {1'b0, ADR_FLAGS}:    rd_mux = {29'h0, flags_sync};
      {1'b0, ADR_LOCK}:     rd_mux = {29'h0, lock_part};
      {1'b0, ADR_IRQ_STAT}: rd_mux = {28'h0, irq_stat};
      ADR_IRQ_EN:           rd_mux = {28'h0, irq_en};
      ADR_WR_CHECK:         rd_mux = {22'h0, chk_locked, chk_addr};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      dat_o    <= '0;
      irq_en   <= '0;
      chk_addr <= '0;
    end else begin
      ack_o <= wb_req;
      dat_o <= rd_mux;
      if (wb_wr && adr_i == ADR_IRQ_EN) irq_en <= dat_i[IRQ_W-1:0];
      if (wb_wr && adr_i == ADR_WR_CHECK) chk_addr <= dat_i[ADDR_W-1:0];
    end
  end

endmodule : scl_core

//--- scl_core_asserts.sv
// Port checks for the serial command block
`timescale 1ns/100ps
module scl_core_asserts (
  // Clock, reset, bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Serial pins
  input wire logic       sck_i,
  input wire logic       cs_n_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_o,
  // Controls
  input wire logic [1:0] fet_o,
  input wire logic [3:0] balance_o,
  input wire logic [1:0] gain_o,
  input wire logic       sleep_o,
  input wire logic [2:0] lock_part_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_CTRL_HOLD: assert property ((cs_n_i && !cyc_i)[*2] |=>
    $stable({fet_o, balance_o, gain_o, sleep_o}))
    else $error("control pins moved while idle");
  AST_LOCK_HOLD: assert property ((cs_n_i && !cyc_i)[*2] |=> $stable(lock_part_o))
    else $error("lock moved while idle");
  AST_OE_START: assert property ($rose(sdo_oe_o) |->
    !(cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3)))
    else $error("output driven without select");
  AST_OE_END: assert property ($rose(cs_n_i) |-> ##[1:8] !sdo_oe_o)
    else $error("output not released");
  AST_OE_IDLE: assert property (cs_n_i[*8] |-> !sdo_oe_o)
    else $error("output driven while idle");
  AST_SDO_EDGE: assert property (sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |->
    !($past(sck_i, 2) && $past(sck_i, 3) && $past(sck_i, 4) && $past(sck_i, 5)))
    else $error("serial out changed without clock fall");
endmodule : scl_core_asserts

//--- scl_host.sv
// Host serial master model
`timescale 1ns/100ps
module scl_host (
  // Serial pins
  output logic      sck_o,
  output logic      sdi_o,
  output logic      cs_n_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic lst = 1'b0;
  // Released line never shows a stale bit
  wire  line = sdo_oe_i ? sdo_i : ~lst;
  initial sck_o = 1'b0;
  initial sdi_o = 1'b0;
  initial cs_n_o = 1'b1;
  always @(sdo_i, sdo_oe_i) if (sdo_oe_i) lst = sdo_i;
  task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    #7.3 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_o = d[23-i];
      #80 sck_o = 1'b1;
      rx = {rx[6:0], line};
      #80 sck_o = 1'b0;
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #40;
  endtask : xfer
endmodule : scl_host

//--- testbench.sv
// Self-checking bench for the serial command block
`timescale 1ns/100ps
module testbench;
  import scl_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat = 32'h0, q, lf = 32'h2A70;
  logic [2:0]  flg = 3'h0;
  logic [7:0]  rx;
  wire  [31:0] rdat;
  wire         ack, sck, sdi, cs_n, sdo, oe, irq, slp;
  wire  [1:0]  fet, gn;
  wire  [3:0]  bal;
  wire  [2:0]  lkp;
  int          error_cnt = 0, cmp_count = 0, ctl = 0, ist = 0;
  int          ad[6] = '{63, 64, 255, 256, 383, 384};
  scl_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .sck_i(sck),
    .sdi_i(sdi), .cs_n_i(cs_n), .sdo_o(sdo), .sdo_oe_o(oe), .flags_i(flg), .fet_o(fet),
    .balance_o(bal), .gain_o(gn), .sleep_o(slp), .lock_part_o(lkp), .irq_o(irq));
  scl_host h (.sck_o(sck), .sdi_o(sdi), .cs_n_o(cs_n), .sdo_i(sdo), .sdo_oe_i(oe));
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #900000;
    error_cnt++;
    end_sim;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic lkd(input int p, input int a);
    return p == 3 || (p == 1 && a >= 384) || (p == 2 && a >= 256)
      || (p > 3 && a < (p == 7 ? 384 : 1 << (p + 2)));
  endfunction : lkd
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic cw(input logic [15:0] d, input int n);
    h.xfer({OP_WRITE_CONTROL, d}, n, rx);
    if (n == 24) ctl = d;
    ist |= (n == 24) ? 1 : 8;
    chk({slp, gn, bal, fet}, ctl[15:7], "ctrl pins");
    wb(0, ADR_CONTROL, 0);
    chk(q, ctl, "ctrl reg");
  endtask : cw
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADR_LOCK, 0);
    chk(q, 0, "lock reset");
    wb(0, 5'h1C, 0);
    chk(q, 0, "unmapped");
    wb(1, {1'b0, ADR_IRQ_EN}, 32'hF);
    // Back-to-back writes, then an aborted one
    repeat (2) begin
      lf = nxt(lf);
      cw(lf[15:0], 24);
    end
    lf = nxt(lf);
    h.xfer({OP_WRITE_CONTROL, lf[31:16]}, 24, rx);
    cw(lf[15:0], 24);
    cw(lf[31:16], 16);
    $display("control test done");
    @(posedge clk_i);
    flg <= {lf[2:1], 1'b1};
    h.xfer({OP_READ_STATUS, 16'h0}, 16, rx);
    ist |= 2;
    chk(rx, {5'h0, flg}, "status");
    $display("status test done");
    for (int p = 0; p < 8; p++) begin
      lf = nxt(lf);
      h.xfer({OP_LOCK_PART, lf[7:3], 3'(p), 8'h0}, 16, rx);
      chk(lkp, p, "lock pins");
      foreach (ad[i]) begin
        wb(1, ADR_WR_CHECK, ad[i]);
        wb(0, ADR_WR_CHECK, 0);
        chk(q[9], lkd(p, ad[i]), "locked");
      end
    end
    ist |= 4;
    $display("lock test done");
    chk(irq, 1, "irq on");
    wb(0, {1'b0, ADR_IRQ_STAT}, 0);
    chk(q, ist, "irq status");
    wb(1, ADR_IRQ_CLR, 32'hF);
    wb(1, ADR_IRQ_EN, 0);
    cw(16'hB3C8, 24);
    chk(irq, 0, "irq masked");
    wb(0, {1'b0, ADR_IRQ_STAT}, 0);
    chk(q, 1, "irq status");
    $display("irq test done");
    end_sim;
  end
endmodule : testbench
bind scl_core scl_core_asserts u_ast (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .sck_i(sck_i), .cs_n_i(cs_n_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .fet_o(fet_o), .balance_o(balance_o), .gain_o(gain_o),
  .sleep_o(sleep_o), .lock_part_o(lock_part_o));
